// ==== core/adcs_clkdiv.sv ====
// Purpose: one-cycle tad enable pulses from the selected divisor
// Assumes: run stays high for the whole conversion
// Notes: counter restarts whenever run is low
`timescale 1ns/10ps
`default_nettype none
module adcs_clkdiv (
  input  wire logic core_clk,
  input  wire logic rstn,
  adcs_conv_if.div  cv
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] div;
  logic       tad_reg;
  logic       tad_next;

  always_comb begin
    case (cv.sel)
      adcs_pkg::CS_DIV2:  div = 7'h02;
      adcs_pkg::CS_DIV8:  div = 7'h08;
      adcs_pkg::CS_DIV32: div = 7'h20;
      adcs_pkg::CS_DIV4:  div = 7'h04;
      adcs_pkg::CS_DIV16: div = 7'h10;
      adcs_pkg::CS_DIV64: div = 7'h40;
      default:            div = 7'(adcs_pkg::FRC_DIV);
    endcase
    cnt_next = 7'h00;
    tad_next = 1'b0;
    if (cv.run) begin
      if (cnt_reg >= div - 7'h01) begin
        tad_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= 7'h00;
      tad_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tad_reg <= tad_next;
    end
  end

  assign cv.tad_en = tad_reg;

  a_tad_div2_spacing: assert property (@(posedge core_clk) disable iff (!rstn)
    (cv.run && cv.sel == 3'h0 && tad_reg) ##1 cv.run |-> ##1 tad_reg)
    else $error("divide-by-two tad pulse missing");
endmodule // adcs_clkdiv
`default_nettype wire

// ==== core/adcs_conv_if.sv ====
// Purpose: carries clock select, tad pulses and sar traffic between modules
// Assumes: single core clock
// Notes: no clocking block
`timescale 1ns/10ps
`default_nettype none
interface adcs_conv_if;
  logic       run;
  logic [2:0] sel;
  logic       tad_en;
  logic       start;
  logic       abort;
  logic       cmp;
  logic       busy;
  logic       done;
  logic [9:0] result;
  logic [9:0] dac;
  modport seq (output run, sel, start, abort, cmp, input tad_en, busy, done, result, dac);
  modport div (input run, sel, output tad_en);
  modport eng (input tad_en, start, abort, cmp, output busy, done, result, dac);
endinterface
`default_nettype wire

// ==== core/adcs_pkg.sv ====
// Purpose: shared constants for the converter control block
// Assumes: registers sit at byte address four times their index
// Notes: one number, one name
package adcs_pkg;
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          FRC_HZ       = 500_000;
  // internal rc clock is 500 kHz at most, so the period rounds up
  localparam int          FRC_DIV      = (CLK_HZ + FRC_HZ - 1) / FRC_HZ;
  localparam int          SAR_BITS     = 10;
  localparam int          PIN_COUNT    = 4;
  localparam int          AW           = 12;

  localparam logic [7:0]  IDX_IRQ_CTRL = 8'h0b;
  localparam logic [7:0]  IDX_PFLAG    = 8'h0c;
  localparam logic [7:0]  IDX_RES_HI   = 8'h1e;
  localparam logic [7:0]  IDX_CTRL     = 8'h1f;
  localparam logic [7:0]  IDX_PEN      = 8'h8c;
  localparam logic [7:0]  IDX_RES_LO   = 8'h9e;
  localparam logic [7:0]  IDX_APS      = 8'h9f;

  localparam int          CTRL_FMT     = 7;
  localparam int          CTRL_VREF    = 6;
  localparam int          CTRL_CHS     = 2;
  localparam int          CTRL_GO      = 1;
  localparam int          CTRL_ON      = 0;
  localparam logic [7:0]  CTRL_MASK    = 8'hdf;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  localparam int          APS_CS       = 4;
  localparam logic [7:0]  APS_MASK     = 8'h7f;
  localparam logic [7:0]  APS_RST      = 8'h0f;

  localparam int          FLAG_BIT     = 6;
  localparam int          GIE_BIT      = 7;
  localparam int          PERIPHERAL_IRQ_ENABLE_BIT     = 6;

  localparam logic [2:0]  CS_DIV2      = 3'h0;
  localparam logic [2:0]  CS_DIV8      = 3'h1;
  localparam logic [2:0]  CS_DIV32     = 3'h2;
  localparam logic [2:0]  CS_DIV4      = 3'h4;
  localparam logic [2:0]  CS_DIV16     = 3'h5;
  localparam logic [2:0]  CS_DIV64     = 3'h6;
endpackage

// ==== core/adcs_sar.sv ====
// Purpose: successive-approximation engine, one bit per tad
// Assumes: cmp high means input is at or above the dac code
// Notes: abort returns to idle without done
`timescale 1ns/10ps
`default_nettype none
module adcs_sar (
  input  wire logic core_clk,
  input  wire logic rstn,
  adcs_conv_if.eng  cv
);
  typedef enum logic [0:0] {ADCS_IDLE, ADCS_CONV} adcs_sar_e;
  adcs_sar_e  st_reg;
  adcs_sar_e  st_next;
  logic [9:0] code_reg;
  logic [9:0] code_next;
  logic [9:0] bit_reg;
  logic [9:0] bit_next;
  logic [9:0] res_reg;
  logic [9:0] res_next;
  logic       done_reg;
  logic       done_next;

  always_comb begin
    st_next   = st_reg;
    code_next = code_reg;
    bit_next  = bit_reg;
    res_next  = res_reg;
    done_next = 1'b0;
    case (st_reg)
      ADCS_IDLE: begin
        if (cv.start) begin
          st_next   = ADCS_CONV;
          code_next = 10'h200;
          bit_next  = 10'h200;
        end
      end
      ADCS_CONV: begin
        if (cv.abort) begin
          st_next = ADCS_IDLE;
        end else if (cv.tad_en) begin
          code_next = cv.cmp ? code_reg : (code_reg & ~bit_reg);
          if (bit_reg[0]) begin
            st_next   = ADCS_IDLE;
            res_next  = code_next;
            done_next = 1'b1;
          end else begin
            bit_next  = bit_reg >> 1;
            code_next = code_next | (bit_reg >> 1);
          end
        end
      end
      default: st_next = ADCS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg   <= ADCS_IDLE;
      code_reg <= 10'h000;
      bit_reg  <= 10'h000;
      res_reg  <= 10'h000;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      code_reg <= code_next;
      bit_reg  <= bit_next;
      res_reg  <= res_next;
      done_reg <= done_next;
    end
  end

  assign cv.busy   = (st_reg == ADCS_CONV);
  assign cv.done   = done_reg;
  assign cv.result = res_reg;
  assign cv.dac    = code_reg;
endmodule // adcs_sar
`default_nettype wire

// ==== core/adcs_top.sv ====
// Purpose: pin select, sequencing and completion signalling of a 10-bit sar converter
// Assumes: apb slave with one wait state; comparator input is asynchronous
// Notes: conversion clock is a tad enable pulse on core_clk
//
// Overview of operation
// - pin select bit one makes the pin analog a cycle later, zero makes it digital; pads are digital during reset
// - analog pins lose digital input buffer, pull-up and change interrupt
// - device clears the start/status bit when conversion completes
// - hold capacitor is never discharged between conversions
// - results have 1024 steps, split over high and low result registers
// - clock select picks divide 2,8,32,4,16,64 or the internal rc clock
// - on completion clear start bit and load the result pair
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module adcs_top (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic [adcs_pkg::AW-1:0]    paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       cmp_in,
  output logic      [9:0]                 dac_code,
  output logic                            sample_en,
  output logic      [2:0]                 chan_sel,
  output logic                            vref_ext_sel,
  output logic                            adc_on,
  output logic      [3:0]                 dig_in_disable,
  output logic      [3:0]                 pullup_disable,
  output logic      [3:0]                 ioc_disable,
  output logic                            irq
);
  adcs_conv_if cv ();

  adcs_clkdiv u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .cv       (cv.div)
  );

  adcs_sar u_sar (
    .core_clk (core_clk),
    .rstn     (rstn),
    .cv       (cv.eng)
  );

  logic [7:0]  ctrl_reg,   ctrl_next;
  logic [7:0]  aps_reg,    aps_next;
  logic [7:0]  pflag_reg,  pflag_next;
  logic [7:0]  pen_reg,    pen_next;
  logic [7:0]  irqc_reg,   irqc_next;
  logic [7:0]  reshi_reg,  reshi_next;
  logic [7:0]  reslo_reg,  reslo_next;
  logic        start_reg,  start_next;
  logic        abort_reg,  abort_next;
  logic        pready_reg, pready_next;
  logic        perr_reg,   perr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [3:0]  pin_reg,    pin_next;
  logic        samp_reg,   samp_next;
  logic        irq_reg,    irq_next;
  logic        cmp_s1_reg, cmp_s2_reg;
  logic [7:0]  idx;
  logic        hit;
  logic        access;
  logic        commit;
  logic        wr;
  logic [7:0]  rd_val;
  logic [7:0]  wd;

  assign idx    = paddr[9:2];
  assign access = psel && penable;
  assign commit = access && pready_reg;
  assign wr     = commit && pwrite && hit;
  assign wd     = pwdata[7:0];

  always_comb begin
    hit = (paddr[1:0] == 2'h0) && (paddr[adcs_pkg::AW-1:10] == '0);
    case (idx)
      adcs_pkg::IDX_IRQ_CTRL: rd_val = irqc_reg;
      adcs_pkg::IDX_PFLAG:    rd_val = pflag_reg;
      adcs_pkg::IDX_RES_HI:   rd_val = reshi_reg;
      adcs_pkg::IDX_CTRL:     rd_val = ctrl_reg;
      adcs_pkg::IDX_PEN:      rd_val = pen_reg;
      adcs_pkg::IDX_RES_LO:   rd_val = reslo_reg;
      adcs_pkg::IDX_APS:      rd_val = aps_reg;
      default: begin
        rd_val = 8'h00;
        hit    = 1'b0;
      end
    endcase
  end

  // bus side: access holds one wait cycle so read data leave a flop
  always_comb begin
    pready_next = access && !pready_reg;
    perr_next   = 1'b0;
    prdata_next = prdata_reg;
    if (access && !pready_reg) begin
      perr_next   = !hit;
      prdata_next = {24'h000000, rd_val};
    end
  end

  always_comb begin
    ctrl_next  = ctrl_reg;
    aps_next   = aps_reg;
    pflag_next = pflag_reg;
    pen_next   = pen_reg;
    irqc_next  = irqc_reg;
    reshi_next = reshi_reg;
    reslo_next = reslo_reg;
    start_next = 1'b0;
    abort_next = 1'b0;
    if (wr) begin
      case (idx)
        adcs_pkg::IDX_IRQ_CTRL: irqc_next = wd;
        adcs_pkg::IDX_PEN:      pen_next  = wd;
        adcs_pkg::IDX_APS:      aps_next  = wd & adcs_pkg::APS_MASK;
        adcs_pkg::IDX_PFLAG:    pflag_next = wd;
        adcs_pkg::IDX_CTRL: begin
          ctrl_next = wd & adcs_pkg::CTRL_MASK;
          // start only with the converter on and idle
          if (!wd[adcs_pkg::CTRL_ON]) begin
            ctrl_next[adcs_pkg::CTRL_GO] = 1'b0;
          end else if (wd[adcs_pkg::CTRL_GO] && !ctrl_reg[adcs_pkg::CTRL_GO]) begin
            start_next = 1'b1;
          end
          if (ctrl_reg[adcs_pkg::CTRL_GO] && !ctrl_next[adcs_pkg::CTRL_GO]) begin
            abort_next = 1'b1;
          end
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
    // a read of the flag register clears only what that read reported
    if (commit && !pwrite && hit && idx == adcs_pkg::IDX_PFLAG) begin
      pflag_next = pflag_reg & ~prdata_reg[7:0];
    end
    if (cv.done) begin
      ctrl_next[adcs_pkg::CTRL_GO]   = 1'b0;
      pflag_next[adcs_pkg::FLAG_BIT] = 1'b1;
      if (ctrl_reg[adcs_pkg::CTRL_FMT]) begin
        reshi_next = cv.result[9:2];
        reslo_next = {cv.result[1:0], 6'h00};
      end else begin
        reshi_next = {6'h00, cv.result[9:8]};
        reslo_next = cv.result[7:0];
      end
    end
  end

  always_comb begin
    pin_next  = aps_reg[adcs_pkg::PIN_COUNT-1:0];
    // the hold switch opens for conversion and while the converter is off; nothing discharges it
    samp_next = ctrl_reg[adcs_pkg::CTRL_ON] && !ctrl_reg[adcs_pkg::CTRL_GO] && !cv.busy;
    irq_next  = pflag_reg[adcs_pkg::FLAG_BIT] && pen_reg[adcs_pkg::FLAG_BIT]
                && irqc_reg[adcs_pkg::PERIPHERAL_IRQ_ENABLE_BIT] && irqc_reg[adcs_pkg::GIE_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_reg   <= adcs_pkg::CTRL_RST;
      aps_reg    <= adcs_pkg::APS_RST;
      pflag_reg  <= 8'h00;
      pen_reg    <= 8'h00;
      irqc_reg   <= 8'h00;
      reshi_reg  <= 8'h00;
      reslo_reg  <= 8'h00;
      start_reg  <= 1'b0;
      abort_reg  <= 1'b0;
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
      prdata_reg <= 32'h00000000;
      pin_reg    <= 4'h0;
      samp_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      aps_reg    <= aps_next;
      pflag_reg  <= pflag_next;
      pen_reg    <= pen_next;
      irqc_reg   <= irqc_next;
      reshi_reg  <= reshi_next;
      reslo_reg  <= reslo_next;
      start_reg  <= start_next;
      abort_reg  <= abort_next;
      pready_reg <= pready_next;
      perr_reg   <= perr_next;
      prdata_reg <= prdata_next;
      pin_reg    <= pin_next;
      samp_reg   <= samp_next;
      irq_reg    <= irq_next;
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  assign cv.run   = cv.busy;
  assign cv.sel   = aps_reg[adcs_pkg::APS_CS+2:adcs_pkg::APS_CS];
  assign cv.start = start_reg;
  assign cv.abort = abort_reg;
  assign cv.cmp   = cmp_s2_reg;

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = perr_reg;
  assign dac_code       = cv.dac;
  assign sample_en      = samp_reg;
  assign chan_sel       = ctrl_reg[adcs_pkg::CTRL_CHS+2:adcs_pkg::CTRL_CHS];
  assign vref_ext_sel   = ctrl_reg[adcs_pkg::CTRL_VREF];
  assign adc_on         = ctrl_reg[adcs_pkg::CTRL_ON];
  assign dig_in_disable = pin_reg;
  assign pullup_disable = pin_reg;
  assign ioc_disable    = pin_reg;
  assign irq            = irq_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_pin_select_map: assert property ((wr && idx == adcs_pkg::IDX_APS) |=> ##1
    dig_in_disable == $past(pwdata[3:0], 2))
    else $error("pin analog bits not reflected on pads");
  a_pad_side_effects: assert property (pullup_disable == dig_in_disable
    && ioc_disable == dig_in_disable)
    else $error("pad disables disagree");
  a_go_clear_done: assert property (cv.done |=> !ctrl_reg[adcs_pkg::CTRL_GO])
    else $error("start bit not cleared on completion");
  a_hold_kept_busy: assert property ($rose(cv.busy) |-> ##1 !sample_en)
    else $error("hold switch closed during conversion");
  a_result_right: assert property ((cv.done && !ctrl_reg[adcs_pkg::CTRL_FMT]) |=>
    reshi_reg[7:2] == 6'h00 && {reshi_reg[1:0], reslo_reg} == $past(cv.result))
    else $error("right justified result wrong");
  a_result_left: assert property ((cv.done && ctrl_reg[adcs_pkg::CTRL_FMT]) |=>
    reslo_reg == {$past(cv.result[1:0]), 6'h00} && reshi_reg == $past(cv.result[9:2]))
    else $error("left justified result wrong");
  a_flag_on_done: assert property (cv.done |=> pflag_reg[adcs_pkg::FLAG_BIT])
    else $error("flag not set on completion");
  a_start_runs: assert property (start_reg |=> cv.busy [*2])
    else $error("conversion did not start");
endmodule // adcs_top
`default_nettype wire

// ==== dv/adcs_tb.sv ====
// Purpose: self-checking bench for the converter control block over apb
// Assumes: comparator modelled from a bench analog value; one wait state apb
// Notes: result checked only for divisors of 8 and up, as the comparator sync needs the settle time
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module tb;
  typedef struct {logic [7:0] idx; logic wr; logic [7:0] wd; logic [7:0] exp; logic err;} adcs_row_s;
  logic        core_clk, rstn, psel, penable, pwrite, cmp_in, pready, pslverr, vref_ext_sel, adc_on;
  logic        sample_en, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  dac_code, ain, r;
  logic [2:0]  chan_sel;
  logic [3:0]  dig_in_disable, pullup_disable, ioc_disable;
  int          miscompares, checks, n, d;
  adcs_row_s   rows [13];

  adcs_top dut (.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .dac_code(dac_code), .sample_en(sample_en), .chan_sel(chan_sel),
    .vref_ext_sel(vref_ext_sel), .adc_on(adc_on), .dig_in_disable(dig_in_disable),
    .pullup_disable(pullup_disable), .ioc_disable(ioc_disable), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // comparator: input at or above the trial code
  always @(posedge core_clk) cmp_in <= (ain >= dac_code);

  function automatic int dv(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return adcs_pkg::FRC_DIV;
    endcase
  endfunction

  // holds the request until pready, then idles one cycle so no signal is driven twice in a step
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    int k;
    k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
    // a slave that never answers is a failure, not a silent skip
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(40000 * 25);
    miscompares++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    cmp_in = 1'b0; ain = 10'h000; miscompares = 0; checks = 0;
    rows = '{'{adcs_pkg::IDX_APS, 0, 8'h00, 8'h0f, 0}, '{adcs_pkg::IDX_CTRL, 0, 8'h00, 8'h00, 0},
      '{adcs_pkg::IDX_PFLAG, 0, 8'h00, 8'h00, 0}, '{adcs_pkg::IDX_PEN, 0, 8'h00, 8'h00, 0},
      '{adcs_pkg::IDX_IRQ_CTRL, 0, 8'h00, 8'h00, 0}, '{adcs_pkg::IDX_RES_HI, 0, 8'h00, 8'h00, 0},
      '{adcs_pkg::IDX_RES_LO, 0, 8'h00, 8'h00, 0}, '{8'h10, 0, 8'h00, 8'h00, 1},
      '{adcs_pkg::IDX_APS, 1, 8'hff, 8'h7f, 0}, '{adcs_pkg::IDX_CTRL, 1, 8'hfe, 8'hdc, 0},
      '{adcs_pkg::IDX_PEN, 1, 8'h40, 8'h40, 0}, '{adcs_pkg::IDX_IRQ_CTRL, 1, 8'hc0, 8'hc0, 0},
      '{8'h20, 1, 8'h5a, 8'h00, 1}};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    `CHK(dig_in_disable, 4'h0, "pads at first edge after reset")
    @(posedge core_clk);
    `CHK(dig_in_disable, 4'hf, "pads after reset")
    foreach (rows[i]) begin
      if (rows[i].wr) apb(rows[i].idx, 1'b1, rows[i].wd);
      apb(rows[i].idx, 1'b0, 8'h00);
      `CHK(er, rows[i].err, "slverr")
      `CHK(rd[7:0], rows[i].exp, "register value")
    end
    `CHK({vref_ext_sel, chan_sel, adc_on}, 5'h1e, "control outputs")
    // direction bits of analog pins are inputs outside this block
    apb(adcs_pkg::IDX_APS, 1'b1, 8'h05);
    repeat (2) @(posedge core_clk);
    `CHK({dig_in_disable, pullup_disable, ioc_disable}, 12'h555, "pad disables")
    // every clock select, left justified, irq enabled
    for (int cs = 0; cs < 8; cs++) begin
      d = dv(cs[2:0]);
      ain <= {cs[2:0], 7'h25};
      r = {cs[2:0], 7'h25};
      apb(adcs_pkg::IDX_APS, 1'b1, {1'b0, cs[2:0], 4'h1});
      apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h81);
      repeat (20) @(posedge core_clk);
      `CHK(sample_en, 1'b1, "hold tracking while idle")
      apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h83);
      n = 2;
      while (irq !== 1'b1 && n < 1200) begin @(posedge core_clk); n++; end
      `CHK(n >= 10 * d && n <= 10 * d + 10, 1'b1, "conversion time")
      repeat (5) @(posedge core_clk);
      `CHK(irq, 1'b1, "irq sticky")
      apb(adcs_pkg::IDX_CTRL, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h81, "start bit cleared")
      if (d >= 8) begin
        apb(adcs_pkg::IDX_RES_HI, 1'b0, 8'h00);
        `CHK(rd[7:0], r[9:2], "left result high")
        apb(adcs_pkg::IDX_RES_LO, 1'b0, 8'h00);
        `CHK(rd[7:0], {r[1:0], 6'h00}, "left result low")
      end
      apb(adcs_pkg::IDX_PFLAG, 1'b0, 8'h00);
      `CHK(rd[7:0], 8'h40, "flag set")
      repeat (2 * d) @(posedge core_clk);
      `CHK(irq, 1'b0, "irq after flag read")
    end
    // masked irq, right justified, completion found by polling
    ain <= 10'h2a5;
    apb(adcs_pkg::IDX_APS, 1'b1, 8'h11);
    apb(adcs_pkg::IDX_PEN, 1'b1, 8'h00);
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h01);
    repeat (20) @(posedge core_clk);
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h03);
    n = 0;
    do begin apb(adcs_pkg::IDX_CTRL, 1'b0, 8'h00); n++; end while (rd[1] !== 1'b0 && n < 60);
    `CHK(rd[7:0], 8'h01, "polled start bit")
    `CHK(irq, 1'b0, "masked irq")
    apb(adcs_pkg::IDX_RES_HI, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h02, "right result high")
    apb(adcs_pkg::IDX_RES_LO, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'ha5, "right result low")
    apb(adcs_pkg::IDX_PFLAG, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h40, "masked flag")
    // start written with converter off is refused
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h02);
    apb(adcs_pkg::IDX_CTRL, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h00, "start while off")
    // abort in mid conversion leaves no flag
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h01);
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h03);
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h01);
    repeat (120) @(posedge core_clk);
    apb(adcs_pkg::IDX_PFLAG, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h00, "no flag after abort")
    // reset in mid conversion
    apb(adcs_pkg::IDX_CTRL, 1'b1, 8'h03);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK({adc_on, irq, pready}, 3'h0, "outputs in reset")
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(adcs_pkg::IDX_CTRL, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h00, "control after reset")
    apb(adcs_pkg::IDX_APS, 1'b0, 8'h00);
    `CHK(rd[7:0], 8'h0f, "pin select after reset")
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
